// File: src/flag_readout_pkg.sv
// constants and types shared by the flag readout design
package flag_readout_pkg;
    // serial frame layout
    localparam int FRAME_BITS   = 16;
    localparam int CNT_W        = 5;
    localparam int BYTE_W       = 8;
    // kind field values (frame bits 15:14)
    localparam logic [1:0] KIND_FLAGS = 2'h3;
    localparam logic [1:0] KIND_LIVE  = 2'h0;
    // group addresses (frame bits 13:9)
    localparam logic [4:0] GRP_REGULATOR = 5'h0F;
    localparam logic [4:0] GRP_BUS_XCVR  = 5'h10;
    localparam logic [4:0] GRP_IO_SUPV   = 5'h11;
    // two bytes per group, byte index = group slot * 2 + byte select
    localparam int NUM_GROUPS   = 3;
    localparam int NUM_BYTES    = NUM_GROUPS * 2;
    localparam int IDX_W        = 3;
    localparam logic [IDX_W-1:0] IDX_REGULATOR = 3'h0;
    localparam logic [IDX_W-1:0] IDX_BUS_XCVR  = 3'h2;
    localparam logic [IDX_W-1:0] IDX_IO_SUPV   = 3'h4;
    // reset and idle values, full frame bit count and counter ceiling
    localparam logic [BYTE_W-1:0] BYTE_ZERO  = 8'h00;
    localparam logic [FRAME_BITS-1:0] WORD_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 5'h00;
    localparam logic [CNT_W-1:0] CNT_FULL   = 5'h10;
    localparam logic [CNT_W-1:0] CNT_MAX    = 5'h1F;

    // received command word, most significant field first
    typedef struct packed {
        logic [1:0] kind;      // bits 15:14
        logic [4:0] group;     // bits 13:9
        logic       marker;    // bit 8, always one, not parity
        logic       byte_sel;  // bit 7
        logic [6:0] pad;       // bits 6:0, sent as zero
    } read_cmd_t;

    typedef logic [NUM_BYTES-1:0][BYTE_W-1:0] byte_bank_t;
endpackage

// File: src/sticky_flag_byte.sv
// one byte of latched failure flags with clear on read
`timescale 1ns/1ps
`default_nettype none
module sticky_flag_byte #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk_in,  // system clock
    input  wire logic             reset_in,    // sync reset, high
    input  wire logic [WIDTH-1:0] fault_in,    // live fault levels
    input  wire logic             clear_in,    // read of this byte
    output logic      [WIDTH-1:0] flags_out    // latched flags
);
    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    // a present fault always sets, so a clear only drops recovered bits
    always_comb begin
        flags_next = fault_in | (flags_reg & ~{WIDTH{clear_in}});
    end

    // latch the flags
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags_out = flags_reg;
endmodule
`default_nettype wire

// File: src/spi_flag_status_readout.sv
// serial read frames returning latched flags or live status bytes
//
// How it works
// - kind 11 reads latched flag bank
// - kind 00 reads live status bank
// - frame bits 13 to 9 address group
// - no parity check on read frames
// - flags latch; read clears only recovered
// - upper response byte is device status
// - lower response byte is previous frame's answer
// - transceiver flags at group 1_0000
`timescale 1ns/1ps
`default_nettype none
module spi_flag_status_readout (
    input  wire logic                           ref_clk_in,   // 125 MHz
    input  wire logic                           reset_in,     // sync, high
    input  wire logic                           sclk_in,      // serial clock
    input  wire logic                           cs_n_in,      // select, low
    input  wire logic                           mosi_in,      // host data
    output logic                                miso_out,     // device data
    output logic                                miso_oe_out,  // miso drive
    input  wire logic [flag_readout_pkg::BYTE_W-1:0]
                                                status_in,    // status byte
    input  wire flag_readout_pkg::byte_bank_t   fault_in,     // fault levels
    input  wire flag_readout_pkg::byte_bank_t   live_in,      // live status
    output flag_readout_pkg::byte_bank_t        flags_out     // latched flags
);
    import flag_readout_pkg::*;

    logic                  sclk_reg;
    logic                  cs_n_reg;
    logic [CNT_W-1:0]      bit_cnt_reg;
    logic [FRAME_BITS-1:0] rx_reg;
    logic [FRAME_BITS-1:0] tx_reg;
    logic [BYTE_W-1:0]     resp_reg;
    logic [NUM_BYTES-1:0]  clear_reg;
    logic                  miso_reg;
    logic                  miso_oe_reg;
    read_cmd_t             cmd;
    logic                  sclk_rise;
    logic                  sclk_fall;
    logic                  frame_start;
    logic                  frame_end;
    logic                  frame_ok;
    logic                  grp_hit;
    logic [IDX_W-1:0]      sel_idx;
    logic [BYTE_W-1:0]     resp_next;
    logic [NUM_BYTES-1:0]  clear_next;

    // edge detection on the sampled serial pins
    assign sclk_rise   = sclk_in & ~sclk_reg & ~cs_n_in;
    assign sclk_fall   = ~sclk_in & sclk_reg & ~cs_n_in;
    assign frame_start = cs_n_reg & ~cs_n_in;
    assign frame_end   = ~cs_n_reg & cs_n_in;
    assign frame_ok    = frame_end && (bit_cnt_reg == CNT_FULL);
    assign cmd         = read_cmd_t'(rx_reg);

    // previous pin levels
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            sclk_reg <= 1'b0;
            cs_n_reg <= 1'b1;
        end else begin
            sclk_reg <= sclk_in;
            cs_n_reg <= cs_n_in;
        end
    end

    // shift in the command on rising serial clock, count the bits
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            rx_reg      <= WORD_ZERO;
            bit_cnt_reg <= CNT_ZERO;
        end else if (frame_start) begin
            bit_cnt_reg <= CNT_ZERO;
        end else if (sclk_rise) begin
            rx_reg <= {rx_reg[FRAME_BITS-2:0], mosi_in};
            if (bit_cnt_reg != CNT_MAX) begin
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
        end
    end

    // group decode; marker bit 8 is never checked as parity
    always_comb begin
        grp_hit = 1'b1;
        sel_idx = IDX_REGULATOR;
        case (cmd.group)
            GRP_REGULATOR: sel_idx = IDX_REGULATOR;
            GRP_BUS_XCVR:  sel_idx = IDX_BUS_XCVR;
            GRP_IO_SUPV:   sel_idx = IDX_IO_SUPV;
            default:       grp_hit = 1'b0;
        endcase
        sel_idx = sel_idx | {2'h0, cmd.byte_sel};
    end

    // pick the answer byte and the flag byte to clear
    always_comb begin
        resp_next  = BYTE_ZERO;
        clear_next = '0;
        if (grp_hit && cmd.kind == KIND_FLAGS) begin
            resp_next           = flags_out[sel_idx];
            clear_next[sel_idx] = 1'b1;
        end else if (grp_hit && cmd.kind == KIND_LIVE) begin
            resp_next = live_in[sel_idx];
        end
    end

    // answer and clear pulse are settled at the end of a whole frame
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            resp_reg  <= BYTE_ZERO;
            clear_reg <= '0;
        end else if (frame_ok) begin
            resp_reg  <= resp_next;
            clear_reg <= clear_next;
        end else begin
            clear_reg <= '0;
        end
    end

    // shift out status then answer, msb first, on falling serial clock
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            tx_reg      <= WORD_ZERO;
            miso_reg    <= 1'b0;
            miso_oe_reg <= 1'b0;
        end else if (frame_start) begin
            tx_reg      <= {status_in, resp_reg};
            miso_reg    <= status_in[BYTE_W-1];
            miso_oe_reg <= 1'b1;
        end else if (frame_end) begin
            miso_oe_reg <= 1'b0;
        end else if (sclk_fall) begin
            tx_reg   <= {tx_reg[FRAME_BITS-2:0], 1'b0};
            miso_reg <= tx_reg[FRAME_BITS-2];
        end
    end

    assign miso_out    = miso_reg;
    assign miso_oe_out = miso_oe_reg;

    // latched flag bytes, one per entry
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BYTES; gi++) begin : g_flags
            sticky_flag_byte #(
                .WIDTH (BYTE_W)
            ) u_flag (
                .ref_clk_in (ref_clk_in),
                .reset_in   (reset_in),
                .fault_in   (fault_in[gi]),
                .clear_in   (clear_reg[gi]),
                .flags_out  (flags_out[gi])
            );
        end
    endgenerate

    // checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    byte_bank_t clr_mask;
    always_comb begin
        for (int i = 0; i < NUM_BYTES; i++) begin
            clr_mask[i] = {BYTE_W{clear_reg[i]}};
        end
    end

    // the edge right after reset compares against a reset cycle, skip it
    chk_fault_sets: assert property (
        !$past(reset_in)
        |-> ($past(fault_in) & ~flags_out) == '0)
        else $error("present fault not latched");

    chk_flag_holds: assert property (
        !$past(reset_in)
        |-> ($past(flags_out) & ~$past(clr_mask) & ~flags_out) == '0)
        else $error("flag dropped without a read");

    chk_clear_recovered: assert property (
        ($past(clr_mask) & ~$past(fault_in) & flags_out) == '0)
        else $error("recovered flag not cleared by read");

    chk_flag_answer: assert property (
        frame_ok && grp_hit && cmd.kind == KIND_FLAGS
        |=> resp_reg == $past(flags_out[sel_idx]) && clear_reg != '0
            ##1 clear_reg == '0)
        else $error("flag read answer or clear wrong");

    chk_live_answer: assert property (
        frame_ok && grp_hit && cmd.kind == KIND_LIVE
        |=> resp_reg == $past(live_in[sel_idx]) && clear_reg == '0)
        else $error("live read answer wrong");

    chk_unmapped_zero: assert property (
        frame_ok && !(grp_hit && (cmd.kind == KIND_FLAGS
                                  || cmd.kind == KIND_LIVE))
        |=> resp_reg == BYTE_ZERO && clear_reg == '0)
        else $error("unmapped read not zero");

    chk_parity_ignored: assert property (
        frame_ok && grp_hit && cmd.kind == KIND_FLAGS && !cmd.marker
        |=> clear_reg != '0)
        else $error("read refused on marker bit");

    chk_status_first: assert property (
        frame_start |=> miso_oe_out && miso_out == $past(status_in[7]))
        else $error("status msb not presented");

    chk_answer_loaded: assert property (
        frame_start |=> tx_reg[BYTE_W-1:0] == $past(resp_reg))
        else $error("answer byte not loaded");

    chk_release_miso: assert property (
        frame_end |=> !miso_oe_out)
        else $error("miso still driven after frame");

    cov_flag_read: cover property (
        frame_ok && grp_hit && cmd.kind == KIND_FLAGS);
    cov_live_read: cover property (
        frame_ok && grp_hit && cmd.kind == KIND_LIVE);
    cov_clear_held: cover property (
        clear_reg != '0 && (fault_in & clr_mask) != '0);
endmodule
`default_nettype wire

// File: dv/spi_host_model.sv
// host side serial master issuing read frames
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input  wire logic ref_clk_in,  // bench clock
    input  wire logic miso_in,     // device data line
    output logic      sclk_out,    // serial clock, idles low
    output logic      cs_n_out,    // select, low
    output logic      mosi_out     // host data
);
    // mode 0 frame, msb first, miso taken just before sclk rises
    task automatic xfer(input logic [15:0] cmd, input int n,
                        output logic [15:0] rsp);
        rsp = 16'h0000;
        @(negedge ref_clk_in) cs_n_out = 1'b0;
        for (int i = 0; i < n; i++) begin
            repeat (3) @(negedge ref_clk_in);
            mosi_out = cmd[15-i];
            repeat (3) @(negedge ref_clk_in);
            rsp = {rsp[14:0], miso_in};
            sclk_out = 1'b1;
            repeat (3) @(negedge ref_clk_in);
            sclk_out = 1'b0;
        end
        repeat (3) @(negedge ref_clk_in);
        cs_n_out = 1'b1;
        mosi_out = ~mosi_out; // released line keeps no stale bit
        repeat (4) @(negedge ref_clk_in);
    endtask
    // idle levels before the first frame
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
endmodule
`default_nettype wire

// File: dv/spi_flag_status_readout_test.sv
// self-checking bench for the serial flag readout
`timescale 1ns/1ps
`default_nettype none
module spi_flag_status_readout_test;
    import flag_readout_pkg::*;
    logic        clk, rst, sclk, cs_n, mosi, miso, miso_oe, miso_w;
    logic [7:0]  status;
    byte_bank_t  fault;
    byte_bank_t  live;
    byte_bank_t  flags;
    int          n_fail = 0;
    int          n_checks = 0;
    int          fm [6] = '{default: 0};
    int          ans = 0;
    logic [31:0] seed = 32'h80B8;
    // read frame words, each with marker bit 8 set
    localparam logic [15:0] RD [6] = '{
        16'hDF00, 16'hDF80, 16'hE100,
        16'hE180, 16'hE300, 16'hE380};

    // released miso shows the inverse of its last bit
    assign miso_w = miso_oe ? miso : ~miso;

    spi_flag_status_readout u_spi_flag_status_readout (
        .ref_clk_in(clk), .reset_in(rst), .sclk_in(sclk), .cs_n_in(cs_n),
        .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe),
        .status_in(status), .fault_in(fault), .live_in(live),
        .flags_out(flags));
    spi_host_model u_spi_host_model (
        .ref_clk_in(clk), .miso_in(miso_w), .sclk_out(sclk),
        .cs_n_out(cs_n), .mosi_out(mosi));

    // free running clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic byte_bank_t mbank();
        for (int i = 0; i < 6; i++) mbank[i] = fm[i][7:0];
    endfunction

    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // faults latch into the model after the design saw them
    task automatic settle();
        repeat (4) @(negedge clk);
        for (int i = 0; i < 6; i++) fm[i] |= fault[i];
    endtask

    // one frame; reply carries the previous frame's answer
    task automatic frame(input logic [15:0] c, input int n);
        logic [15:0] r;
        int          idx;
        @(negedge clk);
        status = 8'(rnd());
        for (int i = 0; i < 6; i++) fm[i] |= fault[i];
        u_spi_host_model.xfer(c, n, r);
        if (n == 16) begin
            chk(r, {status, ans[7:0]});
            idx = (int'(c[13:9]) - 15) * 2 + int'(c[7]);
            if (c[13:9] < 5'h0F || c[13:9] > 5'h11 || c[15] != c[14])
                ans = 0;
            else if (c[15]) begin
                ans = fm[idx];
                fm[idx] &= fault[idx];
            end
            else ans = live[idx];
        end
        chk(flags, mbank());
    endtask

    // watchdog sized well above the expected run
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up();
    end

    // main sequence
    initial begin
        rst = 1'b1;
        fault = '0;
        live = '0;
        status = 8'h00;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk({flags, miso, miso_oe}, 64'h0);
        for (int i = 0; i < 6; i++) fault[i] = 8'(rnd());
        for (int i = 0; i < 6; i++) live[i] = 8'(rnd());
        settle();
        chk(flags, mbank());
        for (int i = 0; i < 6; i++) fault[i] &= 8'(rnd());
        for (int p = 0; p < 12; p++) begin
            frame(RD[p % 6], 16);
        end
        $display("test latched flag reads done");
        for (int k = 0; k < 6; k++) begin
            frame(RD[k] & 16'h3FFF, 16);
        end
        for (int k = 0; k < 6; k++) begin
            frame(RD[k] & 16'hFEFF, 16);
        end
        $display("test live and no parity reads done");
        for (int i = 0; i < 6; i++) fault[i] = 8'(rnd());
        settle();
        fault = '0;
        frame(RD[0] ^ 16'h4000, 16);
        frame(RD[1] ^ 16'h8000, 16);
        frame(16'hE500, 16);
        frame(16'hDD00, 16);
        frame(RD[2], 16);
        frame(RD[3], 15);
        frame(RD[4], 16);
        frame(RD[5], 16);
        frame(RD[0], 16);
        $display("test refused frames done");
        wrap_up();
    end
endmodule
`default_nettype wire
